//--- rtl/timer_pkg.sv
// Shared register map, field positions and timing constants of the timer capture block
package timer_pkg;

  // Register byte offsets
  localparam logic [7:0] ADDR_CTRL    = 8'h00;
  localparam logic [7:0] ADDR_PRIMARY = 8'h04;
  localparam logic [7:0] ADDR_FLAGS   = 8'h08;
  localparam logic [7:0] ADDR_COUNT   = 8'h0c;
  localparam logic [7:0] ADDR_CAPTURE = 8'h10;
  localparam logic [7:0] ADDR_EXTCTL  = 8'h14;
  localparam logic [7:0] ADDR_EXTSTS  = 8'h18;
  localparam logic [7:0] ADDR_CMP0    = 8'h1c;
  localparam logic [7:0] ADDR_CMP1    = 8'h20;
  localparam logic [7:0] ADDR_CMP2    = 8'h24;

  // Interrupt flag register fields
  localparam int FLAG_MAIN   = 0;
  localparam int FLAG_WAKE0  = 1;
  localparam int FLAG_WAKE1  = 2;
  localparam int FLAG_WAKE2  = 3;
  localparam int FLAG_MATCH0 = 4;
  localparam int FLAG_MATCH1 = 5;
  localparam int FLAG_MATCH2 = 6;
  localparam int FLAGS_W     = 7;

  // External control register fields
  localparam int EXT_CNT_PHASE = 0;
  localparam int EXT_EDGE_LSB  = 1;
  localparam int EXT_CAP_EN    = 3;
  localparam int EXT_RST_CAP   = 4;
  localparam int EXT_CAP_IEN   = 5;
  localparam int EXT_CAP_DB    = 6;
  localparam int EXT_CNT_DB    = 7;
  localparam int EXT_CAP_SEL   = 8;

  // External status register fields
  localparam int STS_CAP_IRQ  = 0;
  localparam int STS_CAP_FLAG = 1;

  // Control register fields
  localparam int CTRL_RUN     = 0;
  localparam int CTRL_EVT_EN  = 1;
  localparam int CTRL_SRC_32K = 2;
  localparam int CTRL_DIV_LSB = 8;
  localparam int DIV_W        = 8;

  // Capture edge encodings
  localparam logic [1:0] EDGE_FALL = 2'h0;
  localparam logic [1:0] EDGE_RISE = 2'h1;
  localparam logic [1:0] EDGE_BOTH = 2'h2;

  localparam logic [31:0] RESET_WORD = 32'h0000_0000;

  // Timing
  localparam int CLK_PERIOD_PS    = 8000;
  localparam int DEBOUNCE_TIME_NS = 32;
  localparam int DEBOUNCE_CYCLES  = (DEBOUNCE_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

endpackage : timer_pkg

//--- rtl/edge_if.sv
// Edge pulses from a conditioned pin to the timer core
`timescale 1ns/1ps
interface edge_if;
  logic rise;
  logic fall;
  modport src (output rise, output fall);
  modport dst (input rise, input fall);
endinterface : edge_if

//--- rtl/pin_conditioner.sv
// Synchroniser, optional debounce filter and edge detector for one input pin
`timescale 1ns/1ps
module pin_conditioner #(
  parameter int DB_CYCLES = timer_pkg::DEBOUNCE_CYCLES
) (
  input  wire logic clk,
  input  wire logic resetn,
  input  wire logic pin,
  input  wire logic debounce_en,
  edge_if.src       edges
);
  localparam int CW = $clog2(DB_CYCLES + 1);
  localparam logic [CW-1:0] DB_LAST = CW'(DB_CYCLES - 1);

  logic          sync_a;
  logic          sync_b;
  logic          level;
  logic          level_prev;
  logic [CW-1:0] stable_cnt;

  // Two-stage synchroniser
  always_ff @(posedge clk) begin
    if (!resetn) begin
      sync_a <= 1'b0;
      sync_b <= 1'b0;
    end else begin
      sync_a <= pin;
      sync_b <= sync_a;
    end
  end

  // Level taken at once when debounce_en is low, otherwise accepted only after staying stable
  always_ff @(posedge clk) begin
    if (!resetn) begin
      level      <= 1'b0;
      stable_cnt <= '0;
    end else if (!debounce_en) begin
      level      <= sync_b;
      stable_cnt <= '0;
    end else if (sync_b == level) begin
      stable_cnt <= '0;
    end else if (stable_cnt == DB_LAST) begin
      level      <= sync_b; // RQ20
      stable_cnt <= '0;
    end else begin
      stable_cnt <= stable_cnt + CW'(1);
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      level_prev <= 1'b0;
    end else begin
      level_prev <= level;
    end
  end

  assign edges.rise = level & ~level_prev;
  assign edges.fall = ~level & level_prev;

endmodule : pin_conditioner

//--- rtl/event_prescaler.sv
// Divides a stream of event pulses by prescale plus one
`timescale 1ns/1ps
module event_prescaler #(
  parameter int W = timer_pkg::DIV_W
) (
  input  wire logic         clk,
  input  wire logic         resetn,
  input  wire logic         clear,
  input  wire logic         event_in,
  input  wire logic [W-1:0] prescale_value,
  output logic              tick
);
  logic [W-1:0] div_cnt;

  assign tick = event_in && (div_cnt == prescale_value); // RQ18

  always_ff @(posedge clk) begin
    if (!resetn || clear) begin
      div_cnt <= '0;
    end else if (tick) begin
      div_cnt <= '0;
    end else if (event_in) begin
      div_cnt <= div_cnt + W'(1);
    end
  end

endmodule : event_prescaler

//--- rtl/timer_capture_status_unit.sv
// Timer counter, compare flags, capture and external control behind a classic Wishbone slave
//
// Summary of operation
// RQ1: Match flag 2 (bit 6) sets when counter equals compare value 2.
// RQ2: Match flag 1 (bit 5) sets when counter equals compare value 1.
// RQ3: Match flag 0 (bit 4) sets when counter equals compare value 0.
// RQ4: Main match flag (bit 0) sets when counter equals primary compare value.
// RQ5: Wake flags bits 3..1 set when a time-out wakes a sleeping processor.
// RQ6: Status flags clear only by writing one; zero leaves them alone.
// RQ7: Counter value readable, read-only, counting 32 kHz clock or event pin.
// RQ8: Enabled capture edge sets capture flag and latches counter into capture register.
// RQ9: Capture mode bit 8: zero free or reset mode, one trigger-counting mode.
// RQ10: Bit 7 routes event counting edge detection through debounce filter.
// RQ11: Bit 6 routes capture edge detection through debounce filter.
// RQ12: Bit 5 enables interrupt request while capture interrupt flag is high.
// RQ13: Bit 4 clear: capture only stores counter, counter keeps running.
// RQ14: Bit 4 set: capture stores counter then resets counter to zero.
// RQ15: Bit 3 gates all capture activity.
// RQ16: Edge field: 00 falling, 01 rising, 10 both, 11 reserved.
// RQ17: Bit 0 picks counted event edge: zero falling, one rising.
// RQ18: Source events divided by prescale plus one before the counter.
// RQ19: Capture interrupt flag at bit 0 of external status, needs enable, W1C.
// RQ20: Pins synchronised; debounce accepts level after several stable cycles.
`timescale 1ns/1ps
module timer_capture_status_unit #(
  parameter int DB_CYCLES = timer_pkg::DEBOUNCE_CYCLES
) (
  input  wire logic        clk,
  input  wire logic        resetn,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        event_count_pin,
  input  wire logic        external_capture_pin,
  input  wire logic        clk_32k_in,
  input  wire logic        cpu_sleep,
  output logic             capture_irq
);

  // Software-visible state
  logic [31:0]                  up_counter_value;
  logic [31:0]                  captured_count;
  logic [31:0]                  primary_compare_value;
  logic [31:0]                  compare_value_0;
  logic [31:0]                  compare_value_1;
  logic [31:0]                  compare_value_2;
  logic [timer_pkg::FLAGS_W-1:0] flags;
  logic                         capture_irq_flag;
  logic                         capture_flag;
  logic                         counter_run;
  logic                         event_count_enable;
  logic                         capture_source_32k;
  logic [timer_pkg::DIV_W-1:0]  prescale_value;
  logic                         capture_mode_select;
  logic                         count_pin_debounce_en;
  logic                         capture_pin_debounce_en;
  logic                         capture_irq_enable;
  logic                         reset_on_capture_select;
  logic                         capture_enable;
  logic [1:0]                   capture_edge_select;
  logic                         event_edge_select;

  // Internal datapath
  logic        bus_req;
  logic        wr_en;
  logic [31:0] wmask;
  logic [31:0] rd_word;
  logic        clk32_db_en;
  logic        source_event;
  logic        count_gate;
  logic        triggered;
  logic        count_tick;
  logic        counter_moved;
  logic        cap_rise;
  logic        cap_fall;
  logic        capture_hit;
  logic        match_main;
  logic        match0;
  logic        match1;
  logic        match2;
  logic [timer_pkg::FLAGS_W-1:0] flag_set;
  logic [timer_pkg::FLAGS_W-1:0] flag_clr;

  edge_if count_edges ();
  edge_if capture_edges ();
  edge_if clk32_edges ();

  // Pin conditioning
  pin_conditioner #(.DB_CYCLES(DB_CYCLES)) u_count_pin (
    .clk         (clk),
    .resetn      (resetn),
    .pin         (event_count_pin),
    .debounce_en (count_pin_debounce_en), // RQ10
    .edges       (count_edges)
  );

  pin_conditioner #(.DB_CYCLES(DB_CYCLES)) u_capture_pin (
    .clk         (clk),
    .resetn      (resetn),
    .pin         (external_capture_pin),
    .debounce_en (capture_pin_debounce_en), // RQ11
    .edges       (capture_edges)
  );

  // The 32 kHz clock serves both counting and capture
  assign clk32_db_en = capture_source_32k ? capture_pin_debounce_en : count_pin_debounce_en;

  pin_conditioner #(.DB_CYCLES(DB_CYCLES)) u_clk32 (
    .clk         (clk),
    .resetn      (resetn),
    .pin         (clk_32k_in),
    .debounce_en (clk32_db_en),
    .edges       (clk32_edges)
  );

  // Wishbone slave: one wait state, ack for every address
  assign bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wr_en   = bus_req && wb_we_i;
  assign wmask   = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

  function automatic logic [31:0] merge(input logic [31:0] old_word,
                                        input logic [31:0] new_word,
                                        input logic [31:0] mask);
    merge = (old_word & ~mask) | (new_word & mask);
  endfunction : merge

  always_ff @(posedge clk) begin
    if (!resetn) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= bus_req;
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      wb_dat_o <= timer_pkg::RESET_WORD;
    end else if (bus_req && !wb_we_i) begin
      wb_dat_o <= rd_word;
    end
  end

  always_comb begin
    rd_word = '0;
    unique case (wb_adr_i)
      timer_pkg::ADDR_CTRL: begin
        rd_word[timer_pkg::CTRL_RUN]    = counter_run;
        rd_word[timer_pkg::CTRL_EVT_EN] = event_count_enable;
        rd_word[timer_pkg::CTRL_SRC_32K] = capture_source_32k;
        rd_word[timer_pkg::CTRL_DIV_LSB +: timer_pkg::DIV_W] = prescale_value;
      end
      timer_pkg::ADDR_PRIMARY: rd_word = primary_compare_value;
      timer_pkg::ADDR_FLAGS:   rd_word[timer_pkg::FLAGS_W-1:0] = flags;
      timer_pkg::ADDR_COUNT:   rd_word = up_counter_value; // RQ7
      timer_pkg::ADDR_CAPTURE: rd_word = captured_count;
      timer_pkg::ADDR_EXTCTL: begin
        rd_word[timer_pkg::EXT_CNT_PHASE] = event_edge_select;
        rd_word[timer_pkg::EXT_EDGE_LSB +: 2] = capture_edge_select;
        rd_word[timer_pkg::EXT_CAP_EN]  = capture_enable;
        rd_word[timer_pkg::EXT_RST_CAP] = reset_on_capture_select;
        rd_word[timer_pkg::EXT_CAP_IEN] = capture_irq_enable;
        rd_word[timer_pkg::EXT_CAP_DB]  = capture_pin_debounce_en;
        rd_word[timer_pkg::EXT_CNT_DB]  = count_pin_debounce_en;
        rd_word[timer_pkg::EXT_CAP_SEL] = capture_mode_select;
      end
      timer_pkg::ADDR_EXTSTS: begin
        rd_word[timer_pkg::STS_CAP_IRQ]  = capture_irq_flag;
        rd_word[timer_pkg::STS_CAP_FLAG] = capture_flag;
      end
      timer_pkg::ADDR_CMP0: rd_word = compare_value_0;
      timer_pkg::ADDR_CMP1: rd_word = compare_value_1;
      timer_pkg::ADDR_CMP2: rd_word = compare_value_2;
      default:              rd_word = '0;
    endcase
  end

  // Control register
  always_ff @(posedge clk) begin
    if (!resetn) begin
      counter_run        <= 1'b0;
      event_count_enable <= 1'b0;
      capture_source_32k <= 1'b0;
      prescale_value     <= '0;
    end else if (wr_en && wb_adr_i == timer_pkg::ADDR_CTRL) begin
      if (wb_sel_i[0]) begin
        counter_run        <= wb_dat_i[timer_pkg::CTRL_RUN];
        event_count_enable <= wb_dat_i[timer_pkg::CTRL_EVT_EN];
        capture_source_32k <= wb_dat_i[timer_pkg::CTRL_SRC_32K];
      end
      if (wb_sel_i[1]) begin
        prescale_value <= wb_dat_i[timer_pkg::CTRL_DIV_LSB +: timer_pkg::DIV_W];
      end
    end
  end

  // Compare values
  always_ff @(posedge clk) begin
    if (!resetn) begin
      primary_compare_value <= timer_pkg::RESET_WORD;
      compare_value_0       <= timer_pkg::RESET_WORD;
      compare_value_1       <= timer_pkg::RESET_WORD;
      compare_value_2       <= timer_pkg::RESET_WORD;
    end else if (wr_en) begin
      if (wb_adr_i == timer_pkg::ADDR_PRIMARY) begin
        primary_compare_value <= merge(primary_compare_value, wb_dat_i, wmask);
      end
      if (wb_adr_i == timer_pkg::ADDR_CMP0) begin
        compare_value_0 <= merge(compare_value_0, wb_dat_i, wmask);
      end
      if (wb_adr_i == timer_pkg::ADDR_CMP1) begin
        compare_value_1 <= merge(compare_value_1, wb_dat_i, wmask);
      end
      if (wb_adr_i == timer_pkg::ADDR_CMP2) begin
        compare_value_2 <= merge(compare_value_2, wb_dat_i, wmask);
      end
    end
  end

  // External control register, low byte and bit 8
  always_ff @(posedge clk) begin
    if (!resetn) begin
      event_edge_select       <= 1'b0;
      capture_edge_select     <= timer_pkg::EDGE_FALL;
      capture_enable          <= 1'b0;
      reset_on_capture_select <= 1'b0;
      capture_irq_enable      <= 1'b0;
      capture_pin_debounce_en <= 1'b0;
      count_pin_debounce_en   <= 1'b0;
      capture_mode_select     <= 1'b0;
    end else if (wr_en && wb_adr_i == timer_pkg::ADDR_EXTCTL) begin
      if (wb_sel_i[0]) begin
        event_edge_select       <= wb_dat_i[timer_pkg::EXT_CNT_PHASE];
        capture_edge_select     <= wb_dat_i[timer_pkg::EXT_EDGE_LSB +: 2];
        capture_enable          <= wb_dat_i[timer_pkg::EXT_CAP_EN];
        reset_on_capture_select <= wb_dat_i[timer_pkg::EXT_RST_CAP];
        capture_irq_enable      <= wb_dat_i[timer_pkg::EXT_CAP_IEN];
        capture_pin_debounce_en <= wb_dat_i[timer_pkg::EXT_CAP_DB];
        count_pin_debounce_en   <= wb_dat_i[timer_pkg::EXT_CNT_DB];
      end
      if (wb_sel_i[1]) begin
        capture_mode_select <= wb_dat_i[timer_pkg::EXT_CAP_SEL];
      end
    end
  end

  // Counting source and prescaler
  always_comb begin
    if (event_count_enable) begin
      source_event = event_edge_select ? count_edges.rise : count_edges.fall; // RQ17
    end else begin
      source_event = clk32_edges.rise;
    end
  end

  // Trigger-counting holds the counter until the first capture edge
  assign count_gate = counter_run && (!capture_mode_select || triggered); // RQ9

  always_ff @(posedge clk) begin
    if (!resetn || !counter_run || !capture_mode_select) begin
      triggered <= 1'b0;
    end else if (capture_hit) begin
      triggered <= 1'b1; // RQ9
    end
  end

  event_prescaler #(.W(timer_pkg::DIV_W)) u_prescaler (
    .clk            (clk),
    .resetn         (resetn),
    .clear          (!count_gate),
    .event_in       (source_event && count_gate),
    .prescale_value (prescale_value),
    .tick           (count_tick)
  );

  // Capture edge qualification
  assign cap_rise = capture_source_32k ? clk32_edges.rise : capture_edges.rise;
  assign cap_fall = capture_source_32k ? clk32_edges.fall : capture_edges.fall;

  always_comb begin
    unique case (capture_edge_select) // RQ16
      timer_pkg::EDGE_FALL: capture_hit = capture_enable && cap_fall; // RQ15
      timer_pkg::EDGE_RISE: capture_hit = capture_enable && cap_rise;
      timer_pkg::EDGE_BOTH: capture_hit = capture_enable && (cap_rise || cap_fall);
      default:              capture_hit = 1'b0;
    endcase
  end

  // Up counter
  always_ff @(posedge clk) begin
    if (!resetn) begin
      up_counter_value <= timer_pkg::RESET_WORD;
    end else if (capture_hit && reset_on_capture_select) begin
      up_counter_value <= '0; // RQ14
    end else if (count_tick) begin
      up_counter_value <= up_counter_value + 32'h1; // RQ13
    end
  end

  // Compares act once per counter change
  always_ff @(posedge clk) begin
    if (!resetn) begin
      counter_moved <= 1'b0;
    end else begin
      counter_moved <= count_tick || (capture_hit && reset_on_capture_select);
    end
  end

  assign match_main = counter_moved && (up_counter_value == primary_compare_value); // RQ4
  assign match0     = counter_moved && (up_counter_value == compare_value_0); // RQ3
  assign match1     = counter_moved && (up_counter_value == compare_value_1); // RQ2
  assign match2     = counter_moved && (up_counter_value == compare_value_2); // RQ1

  // Capture register
  always_ff @(posedge clk) begin
    if (!resetn) begin
      captured_count <= timer_pkg::RESET_WORD;
    end else if (capture_hit) begin
      captured_count <= up_counter_value; // RQ8
    end
  end

  // Interrupt flags, set beats clear
  always_comb begin
    flag_set = '0;
    flag_set[timer_pkg::FLAG_MAIN]   = match_main;
    flag_set[timer_pkg::FLAG_MATCH0] = match0;
    flag_set[timer_pkg::FLAG_MATCH1] = match1;
    flag_set[timer_pkg::FLAG_MATCH2] = match2;
    flag_set[timer_pkg::FLAG_WAKE0]  = match0 && cpu_sleep; // RQ5
    flag_set[timer_pkg::FLAG_WAKE1]  = match1 && cpu_sleep;
    flag_set[timer_pkg::FLAG_WAKE2]  = match2 && cpu_sleep;
  end

  always_comb begin
    flag_clr = '0;
    if (wr_en && wb_adr_i == timer_pkg::ADDR_FLAGS && wb_sel_i[0]) begin
      flag_clr = wb_dat_i[timer_pkg::FLAGS_W-1:0]; // RQ6
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      flags <= '0;
    end else begin
      flags <= (flags & ~flag_clr) | flag_set; // RQ6
    end
  end

  // Capture status flags
  always_ff @(posedge clk) begin
    if (!resetn) begin
      capture_irq_flag <= 1'b0;
      capture_flag     <= 1'b0;
    end else begin
      if (capture_hit && capture_irq_enable) begin
        capture_irq_flag <= 1'b1; // RQ19
      end else if (wr_en && wb_adr_i == timer_pkg::ADDR_EXTSTS && wb_sel_i[0]
                   && wb_dat_i[timer_pkg::STS_CAP_IRQ]) begin
        capture_irq_flag <= 1'b0; // RQ19
      end
      if (capture_hit) begin
        capture_flag <= 1'b1; // RQ8
      end else if (wr_en && wb_adr_i == timer_pkg::ADDR_EXTSTS && wb_sel_i[0]
                   && wb_dat_i[timer_pkg::STS_CAP_FLAG]) begin
        capture_flag <= 1'b0;
      end
    end
  end

  // Request to the processor interrupt controller
  always_ff @(posedge clk) begin
    if (!resetn) begin
      capture_irq <= 1'b0;
    end else begin
      capture_irq <= capture_irq_enable && (capture_irq_flag || (capture_hit && capture_irq_enable)); // RQ12
    end
  end

endmodule : timer_capture_status_unit

//--- testbench/pin_partner.sv
// Model of the pins and slow clock that feed the timer block
`timescale 1ns/1ps
module pin_partner #(
  parameter int SLOW_HALF = 50
) (
  input  wire logic clk,
  output logic      event_count_pin,
  output logic      external_capture_pin,
  output logic      clk_32k_in
);
  int n;
  initial begin
    event_count_pin      = 1'b0;
    external_capture_pin = 1'b0;
    clk_32k_in           = 1'b0;
    n                    = 0;
  end
  // Slow clock runs free
  always @(posedge clk) begin
    n <= (n == SLOW_HALF - 1) ? 0 : n + 1;
    if (n == SLOW_HALF - 1) clk_32k_in <= ~clk_32k_in;
  end
  // Level stands hold plus one cycles; hold zero makes a glitch
  task automatic drive(input bit cap, input bit lvl, input int hold);
    @(posedge clk);
    if (cap) external_capture_pin <= lvl;
    else event_count_pin <= lvl;
    repeat (hold) @(posedge clk);
  endtask : drive
endmodule : pin_partner

//--- testbench/timer_capture_status_unit_sva.sv
// Bus and capture interrupt checker for the timer block
`timescale 1ns/1ps
module timer_capture_status_unit_sva #(
  parameter int DB_CYCLES = 4
) (
  input wire logic        clk,
  input wire logic        resetn,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [7:0]  wb_adr_i,
  input wire logic [3:0]  wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  input wire logic        event_count_pin,
  input wire logic        external_capture_pin,
  input wire logic        clk_32k_in,
  input wire logic        cpu_sleep,
  input wire logic        capture_irq
);
  logic       req;
  logic       rd;
  logic       clr;
  logic [8:0] ext_q;
  assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign rd  = req && !wb_we_i;
  assign clr = req && wb_we_i && wb_adr_i == timer_pkg::ADDR_EXTSTS;
  // Shadow of external control bits
  always_ff @(posedge clk) begin
    if (!resetn) begin
      ext_q <= 9'h000;
    end else if (req && wb_we_i && wb_adr_i == timer_pkg::ADDR_EXTCTL) begin
      if (wb_sel_i[0]) ext_q[7:0] <= wb_dat_i[7:0];
      if (wb_sel_i[1]) ext_q[8] <= wb_dat_i[8];
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  ack_after_req_a: assert property (req |=> wb_ack_o) else $error("ack missing");
  ack_single_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
  reset_outputs_a: assert property ($rose(resetn) |-> !wb_ack_o && wb_dat_o == 32'h0 && !capture_irq)
    else $error("outputs not cleared by reset");
  ext_readback_a: assert property (rd && wb_adr_i == timer_pkg::ADDR_EXTCTL
    |=> wb_dat_o == {23'h0, $past(ext_q)}) else $error("control readback");
  unmapped_zero_a: assert property (rd && wb_adr_i[1:0] != 2'h0 |=> wb_dat_o == 32'h0)
    else $error("unmapped read not zero");
  sts_reserved_a: assert property (rd && wb_adr_i == timer_pkg::ADDR_EXTSTS
    |=> wb_dat_o[31:2] == 30'h0) else $error("status reserved bits");
  irq_needs_en_a: assert property (capture_irq |-> $past(ext_q[5])) else $error("irq without enable");
  irq_hold_a: assert property (capture_irq && ext_q[5] && !clr && !$past(clr)
    |=> capture_irq) else $error("irq dropped");
  irq_drop_a: assert property (clr && wb_dat_i[0] && wb_sel_i[0] && !ext_q[5]
    |=> ##1 !capture_irq) else $error("irq not cleared");
  cover property ($rose(capture_irq));
  cover property (clr && wb_dat_i[0]);
  cover property (rd && wb_adr_i == timer_pkg::ADDR_CAPTURE);
endmodule : timer_capture_status_unit_sva

bind timer_capture_status_unit timer_capture_status_unit_sva #(.DB_CYCLES(DB_CYCLES)) sva (
  .clk(clk), .resetn(resetn), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
  .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o), .event_count_pin(event_count_pin), .external_capture_pin(external_capture_pin),
  .clk_32k_in(clk_32k_in), .cpu_sleep(cpu_sleep), .capture_irq(capture_irq)
);

//--- testbench/timer_capture_status_unit_tb_top.sv
// Self-checking bench for the timer capture block
`timescale 1ns/1ps
module timer_capture_status_unit_tb_top;
  logic        clk;
  logic        resetn;
  logic        cyc;
  logic        stb;
  logic        we;
  logic [7:0]  adr;
  logic [3:0]  sel;
  logic [31:0] wdat;
  logic [31:0] rdat;
  logic [31:0] got;
  logic        ack;
  logic        sleep;
  logic        irq;
  logic        ev;
  logic        cp;
  logic        slow;
  int          errors;
  int          check_count;

  timer_capture_status_unit #(.DB_CYCLES(2)) dut (
    .clk(clk), .resetn(resetn), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .event_count_pin(ev),
    .external_capture_pin(cp), .clk_32k_in(slow), .cpu_sleep(sleep), .capture_irq(irq)
  );
  pin_partner pp (.clk(clk), .event_count_pin(ev), .external_capture_pin(cp), .clk_32k_in(slow));

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  task automatic end_sim();
    $display("comparisons %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : end_sim

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    check_count++;
    if (g !== e) begin
      errors++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk

  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    int t;
    t = 0;
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    adr  <= a;
    wdat <= d;
    sel  <= s;
    @(posedge clk);
    while (ack !== 1'b1) begin
      @(posedge clk);
      t++;
    end
    chk(32'(t), 32'h1);
    got = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk);
  endtask : bus

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0, 4'hf);
    chk(got, e);
  endtask : rd_chk

  task automatic pulse(input bit c);
    pp.drive(c, 1'b1, 6);
    pp.drive(c, 1'b0, 6);
  endtask : pulse

  task automatic reset_dut();
    pp.drive(0, 1'b0, 1);
    resetn <= 1'b0;
    repeat (3) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
  endtask : reset_dut

  initial begin
    repeat (20000) @(posedge clk);
    errors++;
    end_sim();
  end

  initial begin
    int k, p, ph, db, r, ien, e, en, hit, x, m;
    resetn = 1'b0;
    cyc    = 1'b0;
    stb    = 1'b0;
    we     = 1'b0;
    adr    = 8'h00;
    sel    = 4'h0;
    wdat   = 32'h0;
    sleep  = 1'b0;
    x = $urandom(79);
    repeat (20) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    for (int a = 8; a <= 20; a += 4) rd_chk(8'(a), 32'h0);
    rd_chk(8'h02, 32'h0);
    rd_chk(8'h3c, 32'h0);
    bus(1'b1, timer_pkg::ADDR_EXTCTL, 32'hffff_ffff, 4'hf);
    bus(1'b1, timer_pkg::ADDR_EXTCTL, 32'h0, 4'h2);
    rd_chk(timer_pkg::ADDR_EXTCTL, 32'h0ff);
    bus(1'b1, timer_pkg::ADDR_COUNT, $urandom, 4'hf);
    bus(1'b1, timer_pkg::ADDR_CAPTURE, $urandom, 4'hf);
    rd_chk(timer_pkg::ADDR_COUNT, 32'h0);
    rd_chk(timer_pkg::ADDR_CAPTURE, 32'h0);
    for (int s = 0; s < 2; s++) begin
      reset_dut();
      sleep <= s[0];
      bus(1'b1, timer_pkg::ADDR_PRIMARY, 32'h2, 4'hf);
      bus(1'b1, timer_pkg::ADDR_CMP0, 32'h3, 4'hf);
      bus(1'b1, timer_pkg::ADDR_CMP1, 32'h5, 4'hf);
      bus(1'b1, timer_pkg::ADDR_CMP2, 32'h7, 4'hf);
      bus(1'b1, timer_pkg::ADDR_CTRL, 32'h3, 4'hf);
      bus(1'b1, timer_pkg::ADDR_EXTCTL, 32'h1, 4'hf);
      repeat (8) pulse(0);
      x = s ? 'h7f : 'h71;
      rd_chk(timer_pkg::ADDR_FLAGS, x);
      bus(1'b1, timer_pkg::ADDR_FLAGS, 32'h0, 4'hf);
      bus(1'b1, timer_pkg::ADDR_FLAGS, 32'h7f, 4'he);
      rd_chk(timer_pkg::ADDR_FLAGS, x);
      bus(1'b1, timer_pkg::ADDR_FLAGS, 32'h55, 4'h1);
      rd_chk(timer_pkg::ADDR_FLAGS, x & 'h2a);
    end
    sleep <= 1'b0;
    repeat (4) begin
      reset_dut();
      p  = $urandom_range(3);
      ph = $urandom_range(1);
      db = $urandom_range(1);
      k  = $urandom_range(8, 1);
      bus(1'b1, timer_pkg::ADDR_CTRL, 32'(p * 256 + 3), 4'hf);
      bus(1'b1, timer_pkg::ADDR_EXTCTL, 32'(db * 128 + ph), 4'hf);
      if (db) begin
        pp.drive(0, 1'b1, 0);
        pp.drive(0, 1'b0, 6);
      end
      repeat (k) pulse(0);
      pp.drive(0, 1'b1, 6);
      rd_chk(timer_pkg::ADDR_COUNT, (k + ph) / (p + 1));
    end
    for (int i = 0; i < 5; i++) begin
      reset_dut();
      k   = $urandom_range(6, 1);
      r   = $urandom_range(1);
      ien = $urandom_range(1);
      db  = $urandom_range(1);
      m   = $urandom_range(1);
      e   = (i == 4) ? 1 : i;
      en  = (i != 4);
      hit = en && e != 3;
      bus(1'b1, timer_pkg::ADDR_CTRL, 32'h3, 4'hf);
      bus(1'b1, timer_pkg::ADDR_EXTCTL, 32'(m * 256 + db * 64 + ien * 32 + r * 16 + en * 8 + e * 2 + 1), 4'hf);
      repeat (k) pulse(0);
      pulse(1);
      rd_chk(timer_pkg::ADDR_CAPTURE, hit ? ((m || (e == 2 && r)) ? 0 : k) : 0);
      rd_chk(timer_pkg::ADDR_COUNT, (m || (hit && r)) ? 0 : k);
      rd_chk(timer_pkg::ADDR_EXTSTS, hit ? 2 + ien : 0);
      chk({31'h0, irq}, 32'(hit && ien));
      bus(1'b1, timer_pkg::ADDR_EXTCTL, 32'h0, 4'hf);
      bus(1'b1, timer_pkg::ADDR_EXTSTS, 32'h3, 4'h1);
      rd_chk(timer_pkg::ADDR_EXTSTS, 32'h0);
      chk({31'h0, irq}, 32'h0);
    end
    end_sim();
  end
endmodule : timer_capture_status_unit_tb_top
